/* hdl/swrc_regs.vh */
// Register offsets, field positions, reset values and timing for the route config block
`ifndef SWRC_REGS_VH
`define SWRC_REGS_VH
// ==========================================================
// Register offsets
`define SWRC_OFF_FAST      8'h00
`define SWRC_OFF_AUX       8'h01
`define SWRC_OFF_TERM      8'h10
`define SWRC_OFF_PULSE1    8'h11
`define SWRC_OFF_PULSE2    8'h12
// ==========================================================
// Reset values
`define SWRC_RST_FAST      8'h40
`define SWRC_RST_AUX       8'h40
`define SWRC_RST_TERM      8'h01
`define SWRC_RST_PULSE     8'h00
`define SWRC_RST_SRC       4'h0
// ==========================================================
// Field positions
`define SWRC_EN_BIT        6
`define SWRC_MODE_HI       5
`define SWRC_MODE_LO       4
`define SWRC_SEL_HI        3
`define SWRC_SEL_LO        0
`define SWRC_TERM_BIT      0
// ==========================================================
// Mode codes
`define SWRC_MODE_QUAD     2'h0
`define SWRC_MODE_DUAL     2'h1
`define SWRC_MODE_SINGLE   2'h2
`define SWRC_MODE_ILLEGAL  2'h3
// ==========================================================
// Termination pulse time
`define SWRC_PULSE_MS      100
`define SWRC_CLK_KHZ       10000
`define SWRC_PULSE_CYC     (`SWRC_PULSE_MS * `SWRC_CLK_KHZ)
`endif

/* hdl/swrc_pulse_timer.v */
// One-shot timer that holds an output high for a set number of cycles
module swrc_pulse_timer #(
  parameter integer CYCLES = 1000000
) (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_start,
  output reg  o_busy
);
  reg  [20:0] count_q;

  // A new start restarts the full interval
  always @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= 21'h00_0000;
      o_busy  <= 1'b0;
    end else if (i_start) begin
      count_q <= CYCLES[20:0] - 21'h00_0001;
      o_busy  <= 1'b1;
    end else if (count_q != 21'h00_0000) begin
      count_q <= count_q - 21'h00_0001;
    end else begin
      o_busy  <= 1'b0;
    end
  end
endmodule // swrc_pulse_timer

/* hdl/swrc_switch_route_config.v */
// Register bank and routing decode for the link crossbar switch
`include "swrc_regs.vh"

// Behaviour
// RULE1: Enable low turns lanes off, standby
// RULE2: Fast mode 00 quad, 01 dual, 10 single
// RULE3: Fast mode 11 ignored, old mode kept
// RULE4: Quad: low two bits pick whole source
// RULE5: Dual: bits 2:0 pick lane pair
// RULE6: Single: four bits pick one lane
// RULE7: Aux enable low disconnects all aux lines
// RULE8: Aux mode 00 quad, 01 dual, 10 single
// RULE9: Aux mode 11 ignored, old mode kept
// RULE10: Aux quad: low bits pick source
// RULE11: Aux dual: A/C or B/D line n
// RULE12: Aux single: one of sixteen lines
// RULE13: Termination select low turns termination off
// RULE14: Pulse-marked lanes lose termination 100 ms
// RULE15: Routing updates only after complete writes
module swrc_switch_route_config #(
  parameter integer PULSE_CYCLES = `SWRC_PULSE_CYC
) (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata,
  output reg         o_fast_lane_enable,
  output reg         o_standby,
  output reg  [15:0] o_fast_out0_sel,
  output reg  [15:0] o_fast_out1_sel,
  output reg  [15:0] o_fast_out2_sel,
  output reg  [15:0] o_fast_out3_sel,
  output reg  [15:0] o_aux_common0_sel,
  output reg  [15:0] o_aux_common1_sel,
  output reg  [15:0] o_aux_common2_sel,
  output reg  [15:0] o_aux_common3_sel,
  output reg  [15:0] o_input_term_on
);
  // ==========================================================
  // Registers
  reg  [7:0]  fast_q;
  reg  [7:0]  aux_q;
  reg  [7:0]  term_q;
  reg  [15:0] term_pulse_sel_q;
  reg  [3:0]  prev_src_q;
  wire [1:0]  wr_mode = i_wdata[`SWRC_MODE_HI:`SWRC_MODE_LO];
  wire        pulse_busy;
  wire        src_change;

  // Lane index n of source s (s: 0=A..3=D) as a one-hot over 16 inputs
  function [15:0] lane_onehot;
    input [1:0] src;
    input [1:0] lane;
    begin
      lane_onehot = 16'h0001 << {src, lane};
    end
  endfunction

  // Pulse bit order: 7:4 A3..A0, 3:0 B3..B0, 15:8 D0..D3 then C0..C3
  function [15:0] pulse_to_lane;
    input [15:0] p;
    begin
      pulse_to_lane = {p[12], p[13], p[14], p[15], p[8], p[9], p[10], p[11],
                       p[3], p[2], p[1], p[0], p[7], p[6], p[5], p[4]};
    end
  endfunction

  // ==========================================================
  // Register writes; illegal mode writes keep the old mode field
  always @(posedge i_clk) begin
    if (i_rst) begin
      fast_q           <= `SWRC_RST_FAST;
      aux_q            <= `SWRC_RST_AUX;
      term_q           <= `SWRC_RST_TERM;
      term_pulse_sel_q <= {`SWRC_RST_PULSE, `SWRC_RST_PULSE};
    end else if (i_wr_en) begin
      case (i_addr)
        `SWRC_OFF_FAST: begin
          fast_q[`SWRC_EN_BIT]                 <= i_wdata[`SWRC_EN_BIT];
          fast_q[`SWRC_SEL_HI:`SWRC_SEL_LO]    <= i_wdata[`SWRC_SEL_HI:`SWRC_SEL_LO];
          if (wr_mode != `SWRC_MODE_ILLEGAL) begin                // see RULE3
            fast_q[`SWRC_MODE_HI:`SWRC_MODE_LO] <= wr_mode;
          end
        end
        `SWRC_OFF_AUX: begin
          aux_q[`SWRC_EN_BIT]                  <= i_wdata[`SWRC_EN_BIT];
          aux_q[`SWRC_SEL_HI:`SWRC_SEL_LO]     <= i_wdata[`SWRC_SEL_HI:`SWRC_SEL_LO];
          if (wr_mode != `SWRC_MODE_ILLEGAL) begin                // see RULE9
            aux_q[`SWRC_MODE_HI:`SWRC_MODE_LO] <= wr_mode;
          end
        end
        `SWRC_OFF_TERM:   term_q[`SWRC_TERM_BIT] <= i_wdata[`SWRC_TERM_BIT];
        `SWRC_OFF_PULSE1: term_pulse_sel_q[7:0]  <= i_wdata;
        `SWRC_OFF_PULSE2: term_pulse_sel_q[15:8] <= i_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read back; unmapped offsets read zero
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        `SWRC_OFF_FAST:   o_rdata <= fast_q;
        `SWRC_OFF_AUX:    o_rdata <= aux_q;
        `SWRC_OFF_TERM:   o_rdata <= term_q;
        `SWRC_OFF_PULSE1: o_rdata <= term_pulse_sel_q[7:0];
        `SWRC_OFF_PULSE2: o_rdata <= term_pulse_sel_q[15:8];
        default:          o_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Termination pulse on source change
  assign src_change = (fast_q[`SWRC_SEL_HI:`SWRC_SEL_LO] != prev_src_q);

  always @(posedge i_clk) begin
    if (i_rst) begin
      prev_src_q <= `SWRC_RST_SRC;
    end else begin
      prev_src_q <= fast_q[`SWRC_SEL_HI:`SWRC_SEL_LO];
    end
  end

  swrc_pulse_timer #(
    .CYCLES (PULSE_CYCLES)
  ) u_pulse_timer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (src_change),
    .o_busy  (pulse_busy)
  );

  // ==========================================================
  // Routing decode; the lane selects are fed only by whole registers, but the termination pulse
  // select is used byte by byte, so it can be half-written (see RULE15)
  wire [1:0]  f_mode      = fast_q[`SWRC_MODE_HI:`SWRC_MODE_LO];
  wire [3:0]  f_sel       = fast_q[`SWRC_SEL_HI:`SWRC_SEL_LO];
  wire [1:0]  a_mode      = aux_q[`SWRC_MODE_HI:`SWRC_MODE_LO];
  wire [3:0]  a_sel       = aux_q[`SWRC_SEL_HI:`SWRC_SEL_LO];
  wire [15:0] f_pair_even = lane_onehot(f_sel[2:1], {f_sel[0], 1'b0});
  wire [15:0] f_pair_odd  = lane_onehot(f_sel[2:1], {f_sel[0], 1'b1});

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_fast_lane_enable <= 1'b0;
      o_standby          <= 1'b1;
      o_fast_out0_sel    <= 16'h0000;
      o_fast_out1_sel    <= 16'h0000;
      o_fast_out2_sel    <= 16'h0000;
      o_fast_out3_sel    <= 16'h0000;
      o_aux_common0_sel  <= 16'h0000;
      o_aux_common1_sel  <= 16'h0000;
      o_aux_common2_sel  <= 16'h0000;
      o_aux_common3_sel  <= 16'h0000;
      o_input_term_on    <= 16'h0000;
    end else begin
      o_fast_lane_enable <= fast_q[`SWRC_EN_BIT];                 // see RULE1
      o_standby          <= ~fast_q[`SWRC_EN_BIT];                // see RULE1
      if (!fast_q[`SWRC_EN_BIT]) begin                            // see RULE1
        o_fast_out0_sel <= 16'h0000;
        o_fast_out1_sel <= 16'h0000;
        o_fast_out2_sel <= 16'h0000;
        o_fast_out3_sel <= 16'h0000;
      end else begin
        case (f_mode)                                             // see RULE2
          `SWRC_MODE_QUAD: begin                                  // see RULE4
            o_fast_out0_sel <= lane_onehot(f_sel[1:0], 2'h0);
            o_fast_out1_sel <= lane_onehot(f_sel[1:0], 2'h1);
            o_fast_out2_sel <= lane_onehot(f_sel[1:0], 2'h2);
            o_fast_out3_sel <= lane_onehot(f_sel[1:0], 2'h3);
          end
          `SWRC_MODE_DUAL: begin                                  // see RULE5
            o_fast_out0_sel <= f_pair_even;
            o_fast_out1_sel <= f_pair_even;
            o_fast_out2_sel <= f_pair_odd;
            o_fast_out3_sel <= f_pair_odd;
          end
          default: begin                                          // see RULE6
            o_fast_out0_sel <= lane_onehot(f_sel[3:2], f_sel[1:0]);
            o_fast_out1_sel <= lane_onehot(f_sel[3:2], f_sel[1:0]);
            o_fast_out2_sel <= lane_onehot(f_sel[3:2], f_sel[1:0]);
            o_fast_out3_sel <= lane_onehot(f_sel[3:2], f_sel[1:0]);
          end
        endcase
      end
      if (!aux_q[`SWRC_EN_BIT]) begin                             // see RULE7
        o_aux_common0_sel <= 16'h0000;
        o_aux_common1_sel <= 16'h0000;
        o_aux_common2_sel <= 16'h0000;
        o_aux_common3_sel <= 16'h0000;
      end else begin
        case (a_mode)                                             // see RULE8
          `SWRC_MODE_QUAD: begin                                  // see RULE10
            o_aux_common0_sel <= lane_onehot(a_sel[1:0], 2'h0);
            o_aux_common1_sel <= lane_onehot(a_sel[1:0], 2'h1);
            o_aux_common2_sel <= lane_onehot(a_sel[1:0], 2'h2);
            o_aux_common3_sel <= lane_onehot(a_sel[1:0], 2'h3);
          end
          `SWRC_MODE_DUAL: begin                                  // see RULE11
            o_aux_common0_sel <= lane_onehot({1'b0, a_sel[2]}, a_sel[1:0]);
            o_aux_common1_sel <= lane_onehot({1'b0, a_sel[2]}, a_sel[1:0]);
            o_aux_common2_sel <= lane_onehot({1'b1, a_sel[2]}, a_sel[1:0]);
            o_aux_common3_sel <= lane_onehot({1'b1, a_sel[2]}, a_sel[1:0]);
          end
          default: begin                                          // see RULE12
            o_aux_common0_sel <= lane_onehot(a_sel[3:2], a_sel[1:0]);
            o_aux_common1_sel <= lane_onehot(a_sel[3:2], a_sel[1:0]);
            o_aux_common2_sel <= lane_onehot(a_sel[3:2], a_sel[1:0]);
            o_aux_common3_sel <= lane_onehot(a_sel[3:2], a_sel[1:0]);
          end
        endcase
      end
      // Pulse only drops lanes while termination is otherwise on
      if (!term_q[`SWRC_TERM_BIT]) begin                          // see RULE13
        o_input_term_on <= 16'h0000;
      end else if (pulse_busy) begin                              // see RULE14
        o_input_term_on <= ~pulse_to_lane(term_pulse_sel_q);
      end else begin
        o_input_term_on <= 16'hFFFF;
      end
    end
  end
endmodule // swrc_switch_route_config

/* tb/swrc_props.sv */
// Concurrent checks on the route config block ports
module swrc_props (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_wr_en,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        o_fast_lane_enable,
  input wire logic        o_standby,
  input wire logic [15:0] o_fast_out0_sel,
  input wire logic [15:0] o_fast_out2_sel,
  input wire logic [15:0] o_aux_common0_sel,
  input wire logic [15:0] o_aux_common3_sel,
  input wire logic [15:0] o_input_term_on
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Write data delayed to line up with the routing latency
  logic [7:0] wd1_q;
  logic [7:0] wd2_q;
  wire        wr_fast = i_wr_en && i_addr == 8'h00;
  wire        wr_aux  = i_wr_en && i_addr == 8'h01;
  always @(posedge i_clk) begin
    wd1_q <= i_wdata;
    wd2_q <= wd1_q;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ====
  // Properties
  property p_stby; o_standby == !o_fast_lane_enable; endproperty
  a_stby: assert property (p_stby) else $error("standby not inverse of enable");
  property p_quiet; !o_fast_lane_enable |-> (o_fast_out0_sel | o_fast_out2_sel) == 16'h0000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("lane select while disabled");
  property p_en; wr_fast && !i_wdata[6] |-> ##2 !o_fast_lane_enable && o_standby; endproperty
  a_en: assert property (p_en) else $error("disable write not applied");
  property p_quad; wr_fast && i_wdata[6:4] == 3'b100
    |-> ##2 o_fast_out0_sel == (16'h0001 << {wd2_q[1:0], 2'b00}); endproperty
  a_quad: assert property (p_quad) else $error("quad routing wrong");
  property p_dual; wr_fast && i_wdata[6:4] == 3'b101
    |-> ##2 o_fast_out2_sel == (16'h0002 << {wd2_q[2:0], 1'b0}); endproperty
  a_dual: assert property (p_dual) else $error("dual routing wrong");
  property p_aux_off; wr_aux && !i_wdata[6]
    |-> ##2 (o_aux_common0_sel | o_aux_common3_sel) == 16'h0000; endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux still connected");
  property p_aux_quad; wr_aux && i_wdata[6:4] == 3'b100
    |-> ##2 o_aux_common3_sel == (16'h0008 << {wd2_q[1:0], 2'b00}); endproperty
  a_aux_quad: assert property (p_aux_quad) else $error("aux quad routing wrong");
  property p_term; i_wr_en && i_addr == 8'h10 && !i_wdata[0]
    |-> ##[1:3] o_input_term_on == 16'h0000; endproperty
  a_term: assert property (p_term) else $error("termination not off");
  property p_onehot; $onehot0(o_fast_out0_sel); endproperty
  a_onehot: assert property (p_onehot) else $error("select not one-hot");
  property p_hold; $changed(o_fast_out0_sel) && !$past(i_rst) && !$past(i_rst, 2)
    |-> $past(i_wr_en, 2); endproperty
  a_hold: assert property (p_hold) else $error("routing moved without write");
  cover property (wr_fast && i_wdata[6:4] == 3'b110);
  cover property (wr_aux && i_wdata[6:4] == 3'b101);
  cover property ($fell(o_input_term_on[4]));
endmodule // swrc_props

/* tb/tb_switch_route_config.sv */
// Directed testbench for the route config block
`include "swrc_regs.vh"
module tb_switch_route_config;
  timeunit 1ns;
  timeprecision 1ns;
  localparam integer PC = 20;
  logic       i_clk, i_rst, i_wr_en, i_rd_en;
  logic [7:0] i_addr, i_wdata;
  wire  [7:0] o_rdata;
  wire        o_fast_lane_enable, o_standby;
  wire [15:0] f0, f1, f2, f3, a0, a1, a2, a3, o_input_term_on;
  wire [63:0] fast_all = {f3, f2, f1, f0};
  wire [63:0] aux_all  = {a3, a2, a1, a0};
  int         n_mismatch, checks_done;
  swrc_switch_route_config #(.PULSE_CYCLES(PC)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_fast_lane_enable(o_fast_lane_enable),
    .o_standby(o_standby), .o_fast_out0_sel(f0), .o_fast_out1_sel(f1), .o_fast_out2_sel(f2),
    .o_fast_out3_sel(f3), .o_aux_common0_sel(a0), .o_aux_common1_sel(a1),
    .o_aux_common2_sel(a2), .o_aux_common3_sel(a3), .o_input_term_on(o_input_term_on));
  // ====
  // Shared tasks
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Routing settles one edge after the write edge; the task waits two edges to cover it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    @(posedge i_clk);
    #1;
    cmp({8'h00, o_rdata}, {8'h00, e});
  endtask
  function automatic logic [15:0] ok(input bit x, input int k);
    return x ? aux_all[k*16 +: 16] : fast_all[k*16 +: 16];
  endfunction
  function automatic logic [7:0] off(input bit x);
    return x ? `SWRC_OFF_AUX : `SWRC_OFF_FAST;
  endfunction
  // ====
  // Scenarios
  task automatic t_reset;
    rd(`SWRC_OFF_FAST, 8'h40);
    rd(`SWRC_OFF_AUX, 8'h40);
    rd(`SWRC_OFF_TERM, 8'h01);
    rd(`SWRC_OFF_PULSE1, 8'h00);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    cmp(f3, 16'h0008);
    cmp(o_input_term_on, 16'hffff);
    $display("test reset done");
  endtask
  task automatic t_quad(input bit x);
    for (int c = 0; c < 4; c++) begin
      wr(off(x), 8'h4c | 8'(c));
      for (int k = 0; k < 4; k++) cmp(ok(x, k), 16'h0001 << (c * 4 + k));
    end
    $display("test quad done");
  endtask
  task automatic t_dual(input bit x);
    logic [15:0] lo;
    for (int p = 0; p < 8; p++) begin
      wr(off(x), 8'h58 | 8'(p));
      lo = 16'h0001 << (x ? p : 2 * p);
      for (int k = 0; k < 4; k++) cmp(ok(x, k), k < 2 ? lo : lo << (x ? 8 : 1));
    end
    $display("test dual done");
  endtask
  task automatic t_single(input bit x);
    for (int c = 0; c < 16; c++) begin
      wr(off(x), 8'h60 | 8'(c));
      cmp(ok(x, 0) | ok(x, 1) | ok(x, 2) | ok(x, 3), 16'h0001 << c);
    end
    $display("test single done");
  endtask
  task automatic t_illegal(input bit x);
    wr(off(x), 8'h51);
    wr(off(x), 8'h73);
    rd(off(x), 8'h53);
    cmp(ok(x, 0), x ? 16'h0008 : 16'h0040);
    $display("test illegal mode done");
  endtask
  task automatic t_off(input bit x);
    wr(off(x), 8'h12);
    cmp(ok(x, 0) | ok(x, 1) | ok(x, 2) | ok(x, 3), 16'h0000);
    cmp({o_standby, o_fast_lane_enable}, x ? 2'b01 : 2'b10);
    wr(off(x), 8'h40);
    $display("test disable done");
  endtask
  task automatic t_term;
    int n;
    wr(`SWRC_OFF_TERM, 8'h00);
    cmp(o_input_term_on, 16'h0000);
    wr(`SWRC_OFF_TERM, 8'h01);
    wr(`SWRC_OFF_PULSE1, 8'h01);
    wr(`SWRC_OFF_FAST, 8'h41);
    repeat (2) @(posedge i_clk);
    #1;
    cmp(o_input_term_on, 16'hffef);
    n = 0;
    while (o_input_term_on[4] !== 1'b1 && n < 2 * PC) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n >= 2 * PC) begin
      n_mismatch++;
      $display("BAD %0t termination pulse never ended", $time);
      conclude;
    end else begin
      cmp(n > PC - 8 && n <= PC + 1, 1'b1);
      wr(`SWRC_OFF_PULSE1, 8'h00);
      wr(`SWRC_OFF_PULSE2, 8'h01);
      wr(`SWRC_OFF_FAST, 8'h42);
      cmp(o_input_term_on, 16'hf7ff);
      rd(`SWRC_OFF_PULSE2, 8'h01);
      wr(`SWRC_OFF_PULSE2, 8'h00);
      wr(`SWRC_OFF_FAST, 8'h43);
      cmp(o_input_term_on, 16'hffff);
      $display("test termination done");
    end
  endtask
  // ====
  // Clock and main sequence
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    {i_rst, i_wr_en, i_rd_en, i_addr, i_wdata} = {3'b100, 16'h0000};
    n_mismatch = 0;
    checks_done = 0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    for (int x = 0; x < 2; x++) begin
      t_quad(x[0]);
      t_dual(x[0]);
      t_single(x[0]);
      t_illegal(x[0]);
      t_off(x[0]);
    end
    t_term;
    conclude;
  end
endmodule // tb_switch_route_config
bind swrc_switch_route_config swrc_props u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_wr_en(i_wr_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_standby(o_standby),
  .o_fast_lane_enable(o_fast_lane_enable), .o_fast_out0_sel(o_fast_out0_sel),
  .o_fast_out2_sel(o_fast_out2_sel), .o_aux_common0_sel(o_aux_common0_sel),
  .o_aux_common3_sel(o_aux_common3_sel), .o_input_term_on(o_input_term_on));
